// >>> bench/tb_agss_switcher.sv
`timescale 1ns/1ps
`include "agss_defs.svh"
// Self-checking bench for the automatic gain set switcher
module tb_agss_switcher;
  import agss_pkg::*;
  localparam int TICK = 10; // Short ms tick keeps ramps a few dozen cycles long
  logic mclk = 1'b0; // System clock
  logic sysRst = 1'b1; // Synchronous reset, high
  logic [7:0] wbAdr = 8'h00; // Bus address
  logic [31:0] wbDatW = 32'h00000000; // Bus write data
  logic [31:0] wbDatR; // Bus read data
  logic wbWe = 1'b0; // Bus write strobe
  logic [3:0] wbSel = 4'h0; // Byte lanes
  logic wbCyc = 1'b0; // Bus cycle
  logic wbStb = 1'b0; // Bus strobe
  logic wbAck; // Bus answer
  logic posDone = 1'b0; // Positioning done input
  logic nearPos = 1'b0; // Near position input
  logic refZero = 1'b0; // Filtered reference is zero
  logic refIn = 1'b0; // Reference input present
  agss_gains_t gains; // Gains in force
  logic setSecond; // Set 2 in force
  logic rampOn; // Ramp in progress
  int nErrors = 0; // Mismatch count
  int numChecks = 0; // Comparison count

  // Free-running clock, 100 MHz
  always #5 mclk = ~mclk;

  agss_switcher #(.MS_TICK_CYCLES(TICK)) agss_switcher_i (
    .mclk(mclk), .sys_rst(sysRst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .positioningDone(posDone), .nearPosition(nearPos), .posRefFilterZero(refZero),
    .posRefInput(refIn), .activeGains(gains), .activeSetSecond(setSecond), .ramping(rampOn)
  );

  // Case equality so an unknown never counts as a match
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wbXfer(input logic [7:0] adr, input logic [31:0] dat, input logic we,
                        output logic [31:0] rdat);
    @(posedge mclk);
    wbAdr <= adr;
    wbDatW <= dat;
    wbWe <= we;
    wbSel <= 4'hF;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    // No assumed latency: only the watchdog ends a missing answer
    do begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  // Register write
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wbXfer(adr, dat, 1'b1, d);
  endtask

  // Register read and compare
  task automatic rdChk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wbXfer(adr, 32'h00000000, 1'b0, d);
    checkVal(what, exp, d);
  endtask

  // Control word: mode, condition code, method, speed loop type
  task automatic ctrl(input logic [3:0] mode, input logic [2:0] code, input logic [1:0] meth,
                      input logic slt);
    wr(`AGSS_ADDR_CTRL, {19'h00000, slt, 2'h0, meth, 1'b0, code, mode});
  endtask

  // Drive the status inputs so that the chosen condition is true or false
  task automatic setCond(input logic [2:0] code, input logic truth);
    @(posedge mclk);
    posDone <= (code == 3'h0) ? truth : (code == 3'h1) ? !truth : 1'b0;
    nearPos <= (code == 3'h2) ? truth : (code == 3'h3) ? !truth : 1'b0;
    refZero <= (code == 3'h4) ? truth : 1'b0;
    refIn <= (code == 3'h5) ? truth : 1'b0;
  endtask

  // Reset values of every setting and of the gains in force
  task automatic testReset();
    logic [15:0] exp [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0190,
                              16'h0190, 16'h01F4, 16'h01F4, 16'h03E8, 16'h03E8};
    checkVal("reset plg", 32'h00000190, {16'h0000, gains.plg});
    checkVal("reset mfg", 32'h000001F4, {16'h0000, gains.mfg});
    checkVal("reset mfc", 32'h000003E8, {16'h0000, gains.mfc});
    checkVal("reset set", 32'h00000000, {31'h0, setSecond});
    for (int i = 0; i < 10; i++) begin
      rdChk("reset param", 8'(8'h04 + 4 * i), {16'h0000, exp[i]});
    end
    rdChk("unmapped read", 8'h40, 32'h00000000);
    rdChk("active plg reg", `AGSS_ADDR_ACT_PLG, 32'h00000190);
    $display("test reset done");
  endtask

  // Boundary values of the setting ranges
  task automatic testRange();
    wr(8'h14, 32'h00000009);
    rdChk("plg below min", 8'h14, 32'h00000190);
    wr(8'h14, 32'h00004E21);
    rdChk("plg above max", 8'h14, 32'h00000190);
    wr(8'h18, 32'h00004E20);
    rdChk("plg at max", 8'h18, 32'h00004E20);
    wr(8'h14, 32'h0000000A);
    rdChk("plg at min", 8'h14, 32'h0000000A);
    wr(8'h20, 32'h0000000A);
    rdChk("mfg at min", 8'h20, 32'h0000000A);
    wr(8'h24, 32'h000001F3);
    rdChk("corr below min", 8'h24, 32'h000003E8);
    wr(8'h28, 32'h000007D0);
    rdChk("corr at max", 8'h28, 32'h000007D0);
    wr(8'h04, 32'h0000FFFF);
    rdChk("wait at max", 8'h04, 32'h0000FFFF);
    wr(8'h14, 32'h00000064);
    wr(8'h18, 32'h0000012C);
    $display("test range done");
  endtask

  // Other control method: parity of the code picks a fixed set
  task automatic testFixed();
    for (int c = 0; c < 6; c++) begin
      ctrl(`AGSS_MODE_AUTO1, 3'(c), 2'h1, 1'b0);
      setCond(3'(c), 1'b1);
      repeat (3) @(posedge mclk);
      checkVal("fixed set", {31'h0, 1'(c % 2)}, {31'h0, setSecond});
      checkVal("fixed plg", (c % 2) ? 32'h12C : 32'h64, {16'h0, gains.plg});
    end
    $display("test fixed done");
  endtask

  // Pattern 1 with waiting and ramping toward set 2, then instant return
  task automatic testAuto();
    int n;
    int m;
    logic held;
    logic [15:0] mid;
    wr(8'h04, 32'h00000002);
    wr(8'h0C, 32'h00000004);
    setCond(3'h0, 1'b0);
    ctrl(`AGSS_MODE_AUTO1, `AGSS_COND_POSITIONING_DONE_ON, `AGSS_METH_POS, 1'b0);
    repeat (4) @(posedge mclk);
    checkVal("start set", 32'h0, {31'h0, setSecond});
    setCond(3'h0, 1'b1);
    n = 0;
    held = 1'b1;
    // Gains must not move before the waiting time has run out
    while (rampOn !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
      if (rampOn !== 1'b1 && gains.plg !== 16'h0064) held = 1'b0;
    end
    checkVal("wait span ok", 32'h1, {31'h0, n >= 2 * TICK && n <= 2 * TICK + 4});
    checkVal("held in wait", 32'h1, {31'h0, held});
    m = 0;
    mid = 16'h0000;
    while (rampOn === 1'b1 && m < 200) begin
      @(posedge mclk);
      m++;
      if (m == 2 * TICK) mid = gains.plg;
    end
    checkVal("ramp span ok", 32'h1, {31'h0, m >= 4 * TICK - 2 && m <= 4 * TICK + 2});
    checkVal("ramp midpoint ok", 32'h1, {31'h0, mid >= 16'h00BE && mid <= 16'h00D2});
    checkVal("end plg", 32'h12C, {16'h0, gains.plg});
    checkVal("end set", 32'h1, {31'h0, setSecond});
    rdChk("end mfg reg", `AGSS_ADDR_ACT_MFG, 32'h0000000A);
    rdChk("end mfc reg", `AGSS_ADDR_ACT_MFC, 32'h000007D0);
    setCond(3'h0, 1'b0);
    repeat (6) @(posedge mclk);
    checkVal("back plg", 32'h64, {16'h0, gains.plg});
    checkVal("back set", 32'h0, {31'h0, setSecond});
    $display("test auto done");
  endtask

  // Every condition code in both directions, both speed loop types
  task automatic testCodes();
    wr(8'h04, 32'h00000000);
    wr(8'h0C, 32'h00000000);
    for (int c = 0; c < 6; c++) begin
      ctrl(`AGSS_MODE_AUTO1, 3'(c), `AGSS_METH_POS, 1'(c % 2));
      rdChk("ctrl readback", `AGSS_ADDR_CTRL, 32'h2 | (c << 4) | ((c % 2) << 12));
      setCond(3'(c), 1'b1);
      repeat (6) @(posedge mclk);
      checkVal("cond true set", 32'h1, {31'h0, setSecond});
      setCond(3'(c), 1'b0);
      repeat (6) @(posedge mclk);
      checkVal("cond false set", 32'h0, {31'h0, setSecond});
    end
    $display("test codes done");
  endtask

  // Revert inside the wait abandons the move; manual mode never switches
  task automatic testRevert();
    logic quiet;
    wr(8'h04, 32'h00000003);
    ctrl(`AGSS_MODE_AUTO1, `AGSS_COND_POSITIONING_DONE_ON, `AGSS_METH_POS, 1'b0);
    setCond(3'h0, 1'b1);
    repeat (10) @(posedge mclk);
    rdChk("status in wait", `AGSS_ADDR_STATUS, 32'h00000019);
    setCond(3'h0, 1'b0);
    quiet = 1'b1;
    repeat (60) begin
      @(posedge mclk);
      if (rampOn !== 1'b0 || setSecond !== 1'b0 || gains.plg !== 16'h0064) quiet = 1'b0;
    end
    checkVal("revert quiet", 32'h1, {31'h0, quiet});
    wr(8'h04, 32'h00000000);
    ctrl(4'h0, `AGSS_COND_POSITIONING_DONE_ON, `AGSS_METH_POS, 1'b0);
    setCond(3'h0, 1'b1);
    repeat (10) @(posedge mclk);
    checkVal("manual holds", 32'h0, {31'h0, setSecond});
    $display("test revert done");
  endtask

  // Verdict and end of run
  task automatic finishTest();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run of a few hundred cycles
  initial begin
    #400000;
    nErrors++;
    $display("[ERR] watchdog expected done seen hang");
    finishTest();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    testReset();
    testRange();
    testFixed();
    testAuto();
    testCodes();
    testRevert();
    finishTest();
  end
endmodule

// >>> core/agss_defs.svh
`ifndef AGSS_DEFS_SVH
`define AGSS_DEFS_SVH

// Register byte offsets
`define AGSS_ADDR_CTRL 8'h00
`define AGSS_ADDR_PARAM0 8'h04
`define AGSS_ADDR_STATUS 8'h2C
`define AGSS_ADDR_ACT_PLG 8'h30
`define AGSS_ADDR_ACT_MFG 8'h34
`define AGSS_ADDR_ACT_MFC 8'h38

// Control register fields
`define AGSS_MODE_MSB 3
`define AGSS_MODE_LSB 0
`define AGSS_COND_MSB 6
`define AGSS_COND_LSB 4
`define AGSS_METH_MSB 9
`define AGSS_METH_LSB 8
`define AGSS_SLT_BIT 12
`define AGSS_CTRL_MASK 32'h0000137F

// Field encodings
`define AGSS_MODE_AUTO1 4'h2
`define AGSS_METH_POS 2'h0
`define AGSS_COND_POSITIONING_DONE_ON 3'h0
`define AGSS_COND_POSITIONING_DONE_OFF 3'h1
`define AGSS_COND_NEAR_ON 3'h2
`define AGSS_COND_NEAR_OFF 3'h3
`define AGSS_COND_REF_IDLE 3'h4
`define AGSS_COND_REF_ON 3'h5

// Parameter table indices
`define AGSS_IDX_WAIT1 4'h0
`define AGSS_IDX_WAIT2 4'h1
`define AGSS_IDX_RAMP1 4'h2
`define AGSS_IDX_RAMP2 4'h3
`define AGSS_IDX_PLG1 4'h4
`define AGSS_IDX_PLG2 4'h5
`define AGSS_IDX_MFG1 4'h6
`define AGSS_IDX_MFG2 4'h7
`define AGSS_IDX_MFC1 4'h8
`define AGSS_IDX_MFC2 4'h9
`define AGSS_NUM_PARAMS 10

// Ranges and reset values
`define AGSS_TIME_MIN 16'h0000
`define AGSS_TIME_MAX 16'hFFFF
`define AGSS_TIME_RST 16'h0000
`define AGSS_GAIN_MIN 16'h000A
`define AGSS_GAIN_MAX 16'h4E20
`define AGSS_PLG_RST 16'h0190
`define AGSS_MFG_RST 16'h01F4
`define AGSS_CORR_MIN 16'h01F4
`define AGSS_CORR_MAX 16'h07D0
`define AGSS_CORR_RST 16'h03E8

// Timing
`define AGSS_MS_PERIOD_NS 1000000
`define AGSS_CLK_PERIOD_NS 10

`endif

// >>> core/agss_pkg.sv
package agss_pkg;

  // One complete gain set as it travels to the servo loops
  typedef struct packed {
    logic [15:0] plg;
    logic [15:0] mfg;
    logic [15:0] mfc;
  } agss_gains_t;

  // Switcher sequence
  typedef enum logic [1:0] {
    ST_STEADY = 2'b00,
    ST_WAIT = 2'b01,
    ST_RAMP = 2'b10
  } agss_state_t;

endpackage

// >>> core/agss_switcher.sv
`timescale 1ns/1ps
`include "agss_defs.svh"
// What this block does
// - Automatic switching only under position control
// - Condition A true: set 1 to 2
// - Condition A false: set 2 to 1
// - Decode six condition A codes
// - Other methods: even code set 1, odd 2
// - Wait configured time before any ramp starts
// - Ramp linearly, done exactly at switching time
// - Two position loop gains, 10..20000, default 400
// - Two model-following gains, 10..20000, default 500
// - Two corrections, 500..2000, default 1000
// - Switching works for PI and I-P
// - Four times, 0..65535 ms, default 0, immediate
module agss_switcher #(
  parameter int MS_TICK_CYCLES = `AGSS_MS_PERIOD_NS / `AGSS_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic positioningDone,
  input wire logic nearPosition,
  input wire logic posRefFilterZero,
  input wire logic posRefInput,
  output agss_pkg::agss_gains_t activeGains,
  output logic activeSetSecond,
  output logic ramping
);
  import agss_pkg::*;

  localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);

  // Per-entry limits and reset values of the parameter table
  localparam logic [15:0] P_MIN [0:9] = '{`AGSS_TIME_MIN, `AGSS_TIME_MIN,
    `AGSS_TIME_MIN, `AGSS_TIME_MIN, `AGSS_GAIN_MIN, `AGSS_GAIN_MIN,
    `AGSS_GAIN_MIN, `AGSS_GAIN_MIN, `AGSS_CORR_MIN, `AGSS_CORR_MIN};
  localparam logic [15:0] P_MAX [0:9] = '{`AGSS_TIME_MAX, `AGSS_TIME_MAX,
    `AGSS_TIME_MAX, `AGSS_TIME_MAX, `AGSS_GAIN_MAX, `AGSS_GAIN_MAX,
    `AGSS_GAIN_MAX, `AGSS_GAIN_MAX, `AGSS_CORR_MAX, `AGSS_CORR_MAX};
  localparam logic [15:0] P_RST [0:9] = '{`AGSS_TIME_RST, `AGSS_TIME_RST,
    `AGSS_TIME_RST, `AGSS_TIME_RST, `AGSS_PLG_RST, `AGSS_PLG_RST,
    `AGSS_MFG_RST, `AGSS_MFG_RST, `AGSS_CORR_RST, `AGSS_CORR_RST};

  logic [31:0] ctrl_r; // Mode, condition, control method, loop type
  logic [15:0] param_r [0:9]; // Waits, ramps and both gain sets
  agss_state_t state_r; // Sequence state
  logic tgtSecond_r; // Set being approached
  logic setSecond_r; // Set currently in force
  agss_gains_t gains_r; // Gains driven to the loops
  agss_gains_t src_r; // Gains captured when a move started
  logic [15:0] msCnt_r; // Whole milliseconds in the current phase
  logic [TICK_W-1:0] tickCnt_r; // Clock cycles within one millisecond
  logic ack_r; // Bus acknowledge
  logic ramping_r; // Ramp in progress, kept in a flop for the output pin
  logic [31:0] rdat_r; // Bus read data

  logic busReq; // Fresh request this cycle
  logic busWr; // Write that lands at the acknowledged edge
  logic [3:0] mode; // Switch selector field
  logic [2:0] condCode; // Condition A field
  logic posCtrl; // Position control active
  logic autoEn; // Automatic switching live
  logic condA; // Decoded condition A
  logic wantSecond; // Set that the condition asks for
  logic msTick; // One-millisecond strobe
  logic [15:0] waitTime; // Waiting time of the pending move
  logic [15:0] rampTime; // Switching time of the pending move
  agss_gains_t set1; // Gain set 1 as programmed
  agss_gains_t set2; // Gain set 2 as programmed
  agss_gains_t tgtGains; // Gains of the target set
  agss_gains_t lerpGains; // Interpolated gains for the ramp
  logic [16:0] frac; // Ramp progress, 1.0 equals 17'h10000

  assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
  // Writes land on the edge where the master samples ack, while it still holds the request
  assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign mode = ctrl_r[`AGSS_MODE_MSB:`AGSS_MODE_LSB];
  assign condCode = ctrl_r[`AGSS_COND_MSB:`AGSS_COND_LSB];
  assign posCtrl = ctrl_r[`AGSS_METH_MSB:`AGSS_METH_LSB] == `AGSS_METH_POS;
  // Loop type bit is deliberately not a term here: PI and I-P both switch
  assign autoEn = posCtrl && (mode == `AGSS_MODE_AUTO1);
  assign set1 = '{plg: param_r[`AGSS_IDX_PLG1], mfg: param_r[`AGSS_IDX_MFG1],
    mfc: param_r[`AGSS_IDX_MFC1]};
  assign set2 = '{plg: param_r[`AGSS_IDX_PLG2], mfg: param_r[`AGSS_IDX_MFG2],
    mfc: param_r[`AGSS_IDX_MFC2]};
  assign tgtGains = tgtSecond_r ? set2 : set1;
  // Target 2 uses the first timings, target 1 the second
  assign waitTime = tgtSecond_r ? param_r[`AGSS_IDX_WAIT1] : param_r[`AGSS_IDX_WAIT2];
  assign rampTime = tgtSecond_r ? param_r[`AGSS_IDX_RAMP1] : param_r[`AGSS_IDX_RAMP2];

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    laneMerge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Linear interpolation; exact at both ends since frac reaches 1.0
  function automatic logic [15:0] lerp(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic [16:0] f);
    logic signed [17:0] d;
    logic signed [35:0] p;
    logic signed [35:0] s;
    d = $signed({2'b00, b}) - $signed({2'b00, a});
    p = d * $signed({1'b0, f});
    s = $signed({4'h0, a, 16'h0000}) + p;
    lerp = s[31:16];
  endfunction

  // Condition A decode; unused codes read as not satisfied
  always_comb begin
    case (condCode)
      `AGSS_COND_POSITIONING_DONE_ON: condA = positioningDone;
      `AGSS_COND_POSITIONING_DONE_OFF: condA = !positioningDone;
      `AGSS_COND_NEAR_ON: condA = nearPosition;
      `AGSS_COND_NEAR_OFF: condA = !nearPosition;
      `AGSS_COND_REF_IDLE: condA = posRefFilterZero && !posRefInput;
      `AGSS_COND_REF_ON: condA = posRefInput;
      default: condA = 1'b0;
    endcase
  end

  // Set wanted now: condition in auto, fixed by code parity under other methods, held in manual position mode
  always_comb begin
    if (autoEn) begin
      wantSecond = condA;
    end else if (!posCtrl) begin
      wantSecond = condCode[0];
    end else begin
      wantSecond = setSecond_r;
    end
  end

  // Ramp progress; division done once for all three gains
  always_comb begin
    if (rampTime == 16'h0000 || msCnt_r >= rampTime) begin
      frac = 17'h10000;
    end else begin
      frac = 17'(({msCnt_r, 16'h0000}) / {16'h0000, rampTime});
    end
    lerpGains.plg = lerp(src_r.plg, tgtGains.plg, frac);
    lerpGains.mfg = lerp(src_r.mfg, tgtGains.mfg, frac);
    lerpGains.mfc = lerp(src_r.mfc, tgtGains.mfc, frac);
  end

  // Wishbone acknowledge, one cycle after the strobe, never twice in a row
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdat_r <= 32'h00000000;
    end else if (busReq && !wb_we_i) begin
      if (wb_adr_i == `AGSS_ADDR_CTRL) begin
        rdat_r <= ctrl_r;
      end else if (wb_adr_i >= `AGSS_ADDR_PARAM0 && wb_adr_i < `AGSS_ADDR_STATUS &&
                   wb_adr_i[1:0] == 2'b00) begin
        rdat_r <= {16'h0000, param_r[4'(wb_adr_i[7:2] - 6'h01)]};
      end else if (wb_adr_i == `AGSS_ADDR_STATUS) begin
        rdat_r <= {27'h0000000, autoEn, tgtSecond_r, setSecond_r, state_r};
      end else if (wb_adr_i == `AGSS_ADDR_ACT_PLG) begin
        rdat_r <= {16'h0000, gains_r.plg};
      end else if (wb_adr_i == `AGSS_ADDR_ACT_MFG) begin
        rdat_r <= {16'h0000, gains_r.mfg};
      end else if (wb_adr_i == `AGSS_ADDR_ACT_MFC) begin
        rdat_r <= {16'h0000, gains_r.mfc};
      end else begin
        rdat_r <= 32'h00000000;
      end
    end
  end

  // Control register; unused bits stay zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= 32'h00000000;
    end else if (busWr && wb_adr_i == `AGSS_ADDR_CTRL) begin
      ctrl_r <= {laneMerge(ctrl_r[31:16], wb_dat_i >> 16, wb_sel_i >> 2),
                 laneMerge(ctrl_r[15:0], wb_dat_i, wb_sel_i)} & `AGSS_CTRL_MASK;
    end
  end

  // Parameter table; a write outside the legal range is dropped whole
  genvar gi;
  generate
    for (gi = 0; gi < `AGSS_NUM_PARAMS; gi++) begin : g_param
      logic [15:0] mergedVal; // Value after byte-lane merge
      assign mergedVal = laneMerge(param_r[gi], wb_dat_i, wb_sel_i);
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          param_r[gi] <= P_RST[gi];
        end else if (busWr && wb_adr_i == 8'(`AGSS_ADDR_PARAM0 + 4 * gi) &&
                     mergedVal >= P_MIN[gi] && mergedVal <= P_MAX[gi]) begin
          param_r[gi] <= mergedVal;
        end
      end
    end
  endgenerate

  // Millisecond strobe, restarted only while the sequencer sits in steady
  assign msTick = tickCnt_r == TICK_W'(MS_TICK_CYCLES - 1);
  always_ff @(posedge mclk) begin
    if (sys_rst || state_r == ST_STEADY || msTick) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  // Sequencer: steady, wait, ramp. Times are read live so edits act at once
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_STEADY;
      ramping_r <= 1'b0;
      tgtSecond_r <= 1'b0;
      setSecond_r <= 1'b0;
      msCnt_r <= 16'h0000;
      src_r <= '{plg: `AGSS_PLG_RST, mfg: `AGSS_MFG_RST, mfc: `AGSS_CORR_RST};
      gains_r <= '{plg: `AGSS_PLG_RST, mfg: `AGSS_MFG_RST, mfc: `AGSS_CORR_RST};
    end else if (!autoEn) begin
      // Fixed set, no timing; any move in flight is dropped
      state_r <= ST_STEADY;
      ramping_r <= 1'b0;
      setSecond_r <= wantSecond;
      tgtSecond_r <= wantSecond;
      msCnt_r <= 16'h0000;
      gains_r <= wantSecond ? set2 : set1;
    end else begin
      case (state_r)
        ST_STEADY: begin
          if (wantSecond != setSecond_r) begin
            state_r <= ST_WAIT;
            tgtSecond_r <= wantSecond;
            src_r <= gains_r;
            msCnt_r <= 16'h0000;
          end else begin
            // Track parameter edits of the set in force
            gains_r <= setSecond_r ? set2 : set1;
          end
        end
        ST_WAIT: begin
          if (wantSecond != tgtSecond_r) begin
            // Condition reverted: gains held in the wait, steady reloads the set in force
            state_r <= ST_STEADY;
            tgtSecond_r <= setSecond_r;
            msCnt_r <= 16'h0000;
          end else if (msCnt_r >= waitTime) begin
            state_r <= ST_RAMP;
            ramping_r <= 1'b1;
            src_r <= gains_r;
            msCnt_r <= 16'h0000;
          end else if (msTick) begin
            msCnt_r <= msCnt_r + 16'h0001;
          end
        end
        ST_RAMP: begin
          if (wantSecond != tgtSecond_r) begin
            // Reverse from wherever the ramp has reached
            state_r <= ST_WAIT;
            ramping_r <= 1'b0;
            tgtSecond_r <= wantSecond;
            setSecond_r <= !wantSecond;
            src_r <= gains_r;
            msCnt_r <= 16'h0000;
          end else if (msCnt_r >= rampTime) begin
            state_r <= ST_STEADY;
            ramping_r <= 1'b0;
            setSecond_r <= tgtSecond_r;
            gains_r <= tgtGains;
            msCnt_r <= 16'h0000;
          end else begin
            gains_r <= lerpGains;
            if (msTick) begin
              msCnt_r <= msCnt_r + 16'h0001;
            end
          end
        end
        default: begin
          state_r <= ST_STEADY;
          ramping_r <= 1'b0;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign activeGains = gains_r;
  assign activeSetSecond = setSecond_r;
  assign ramping = ramping_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_no_auto_switch: assert property (!autoEn |=> state_r == ST_STEADY)
    else $error("sequencer active outside automatic position control");
  a_up_wait_first: assert property ($rose(state_r == ST_RAMP) && tgtSecond_r
    |-> $past(msCnt_r) >= $past(param_r[`AGSS_IDX_WAIT1]))
    else $error("move to set 2 left wait early");
  a_down_wait_second: assert property ($rose(state_r == ST_RAMP) && !tgtSecond_r
    |-> $past(msCnt_r) >= $past(param_r[`AGSS_IDX_WAIT2]))
    else $error("move to set 1 left wait early");
  a_cond_ref_on: assert property (condCode == `AGSS_COND_REF_ON |-> condA == posRefInput)
    else $error("reference-present condition decoded wrongly");
  a_fixed_set: assert property (!posCtrl ##1 !posCtrl |-> setSecond_r == $past(condCode[0]))
    else $error("fixed set does not follow condition code");
  a_wait_hold: assert property (state_r == ST_WAIT && $past(state_r) == ST_WAIT
    && autoEn && $past(autoEn) |-> $stable(gains_r))
    else $error("gains moved during waiting time");
  a_ramp_end: assert property (state_r == ST_RAMP && autoEn && msCnt_r >= rampTime
    && wantSecond == tgtSecond_r ##1 autoEn |-> gains_r == $past(tgtGains))
    else $error("ramp did not finish on target");
  a_plg_range: assert property (param_r[`AGSS_IDX_PLG2] >= `AGSS_GAIN_MIN
    && param_r[`AGSS_IDX_PLG2] <= `AGSS_GAIN_MAX)
    else $error("second position gain out of range");
  a_corr_range: assert property (param_r[`AGSS_IDX_MFC1] >= `AGSS_CORR_MIN
    && param_r[`AGSS_IDX_MFC1] <= `AGSS_CORR_MAX)
    else $error("correction out of range");
  a_mfg_range: assert property (param_r[`AGSS_IDX_MFG2] >= `AGSS_GAIN_MIN
    && param_r[`AGSS_IDX_MFG2] <= `AGSS_GAIN_MAX)
    else $error("second model-following gain out of range");
  a_revert_abort: assert property (state_r == ST_WAIT && autoEn && wantSecond != tgtSecond_r
    |=> state_r != ST_RAMP)
    else $error("reverted condition still ramped");

  c_enter_ramp: cover property ($rose(state_r == ST_RAMP));
  c_fixed_set: cover property (!posCtrl && setSecond_r);
  c_ramp_done: cover property (state_r == ST_RAMP ##1 state_r == ST_STEADY && setSecond_r);
  c_wait_revert: cover property (state_r == ST_WAIT ##1 state_r == ST_STEADY && !ramping);
endmodule
